// ===== hdl/qdc_pkg.sv
// shared constants and types for the quad dac serial control block
package qdc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // serial word layout
  localparam int WORD_W = 32;
  localparam int CMD_POS = 20;
  localparam int ADDR_POS = 16;
  localparam int DATA_POS = 0;
  localparam int CODE_W = 16;
  localparam int CHAN_N = 4;

  ////////////////////////////////////////////////////////////////////////////
  // command_field codes
  localparam logic [3:0] CMD_WRITE = 4'h0;
  localparam logic [3:0] CMD_UPDATE = 4'h1;
  localparam logic [3:0] CMD_WRITE_UPD_ALL = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
  localparam logic [3:0] CMD_POWER_DOWN = 4'h4;
  localparam logic [3:0] CMD_NOP = 4'hf;

  // channel_address_field codes
  localparam logic [3:0] ADDR_CHAN_A = 4'h0;
  localparam logic [3:0] ADDR_CHAN_B = 4'h1;
  localparam logic [3:0] ADDR_CHAN_C = 4'h2;
  localparam logic [3:0] ADDR_CHAN_D = 4'h3;
  localparam logic [3:0] ADDR_ALL = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // power-up settling times and their cycle counts
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SETTLE_PART_NS = 5000;
  localparam int SETTLE_FULL_5V_NS = 12000;
  localparam int SETTLE_FULL_3V_NS = 30000;
  localparam int SETTLE_PART_CYC =
    (SETTLE_PART_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_FULL_5V_CYC =
    (SETTLE_FULL_5V_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_FULL_3V_CYC =
    (SETTLE_FULL_3V_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_W = 13;

  ////////////////////////////////////////////////////////////////////////////
  // control sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } qdc_state_t;

endpackage : qdc_pkg

// ===== hdl/qdc_sync.sv
// two flip-flop level synchroniser
module qdc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } qdc_sync_t;

  qdc_sync_t q;
  qdc_sync_t next_q;

  // first stage feeds only the second stage
  always_comb begin
    next_q.meta = d_i;
    next_q.sync = q.meta;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= {RST_VAL, RST_VAL};
    end else begin
      q <= next_q;
    end
  end

  assign q_o = q.sync;

endmodule : qdc_sync

// ===== hdl/qdc_link_shift.sv
// serial link shift register on the link clock
module qdc_link_shift (
  // link clock and reset
  input wire logic sck_i,
  input wire logic rst_b_i,
  // serial pins
  input wire logic select_load_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  // captured word
  output logic [31:0] shift_o
);

  typedef struct packed {
    logic [31:0] shift;
  } qdc_link_t;

  qdc_link_t q;
  qdc_link_t next_q;
  logic out_bit;

  always_comb begin
    next_q = q;
    if (!select_load_n_i) begin
      next_q.shift = {q.shift[30:0], serial_in_i};
    end
  end

  always_ff @(posedge sck_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= qdc_pkg::WORD_RST;
    end else begin
      q <= next_q;
    end
  end

  // falling edge launch gives the next chip a full half period of setup
  always_ff @(negedge sck_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_bit <= 1'b0;
    end else begin
      out_bit <= q.shift[31];
    end
  end

  assign serial_out_o = out_bit;
  assign shift_o = q.shift;

  chk_idle_no_shift: assert property (
    @(posedge sck_i) disable iff (!rst_b_i)
    select_load_n_i |=> $stable(q.shift))
    else $error("shift register moved while deselected");

  chk_bit_shifted_in: assert property (
    @(posedge sck_i) disable iff (!rst_b_i)
    !select_load_n_i |=> q.shift[0] == $past(serial_in_i))
    else $error("serial input bit not captured");

endmodule : qdc_link_shift

// ===== hdl/qdc_serial_ctrl.sv
// quad dac serial command decoder and channel registers
module qdc_serial_ctrl #(
  parameter int SETTLE_PART_CYC = qdc_pkg::SETTLE_PART_CYC,
  parameter int SETTLE_FULL_5V_CYC = qdc_pkg::SETTLE_FULL_5V_CYC,
  parameter int SETTLE_FULL_3V_CYC = qdc_pkg::SETTLE_FULL_3V_CYC
) (
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // serial link
  input wire logic sck_i,
  input wire logic select_load_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  // clear and supply strap
  input wire logic async_clear_n_i,
  input wire logic low_supply_i,
  // channel state
  output logic [3:0][15:0] input_code_o,
  output logic [3:0][15:0] dac_code_o,
  output logic [3:0] power_down_o,
  output logic settling_o,
  output logic exec_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    qdc_pkg::qdc_state_t st;
    logic cs_d;
    logic [31:0] word;
    logic [3:0][15:0] in_reg;
    logic [3:0][15:0] dac_reg;
    logic [3:0] pd;
    logic [12:0] settle;
  } qdc_ctrl_t;

  qdc_ctrl_t q;
  qdc_ctrl_t next_q;

  logic rst_n;
  logic [2:0] pin_sync;
  logic cs_sync;
  logic clr_sync;
  logic low_sync;
  logic cs_rise;
  logic [31:0] link_word;

  logic [3:0] cmd;
  logic [3:0] addr;
  logic [15:0] data;
  logic [3:0] sel;
  logic is_write;
  logic is_pd;
  logic [3:0] up_en;
  logic [3:0] wake;
  logic [12:0] settle_load;
  logic [3:0][15:0] in_nx;
  logic [3:0][15:0] dac_nx;
  logic [3:0] pd_nx;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  qdc_sync #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_rst_sync (
    .clk_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .d_i(1'b1),
    .q_o(rst_n)
  );

  qdc_sync #(
    .W(3),
    .RST_VAL(3'h6)
  ) u_pin_sync (
    .clk_i(clk_sys_i),
    .rst_b_i(rst_n),
    .d_i({select_load_n_i, async_clear_n_i, low_supply_i}),
    .q_o(pin_sync)
  );

  assign cs_sync = pin_sync[2];
  assign clr_sync = pin_sync[1];
  assign low_sync = pin_sync[0];

  ////////////////////////////////////////////////////////////////////////////
  // link side shifter

  // shifting is gated off while deselected, so the word stays still
  // once select is high and can be read here without a further handshake
  qdc_link_shift u_link (
    .sck_i(sck_i),
    .rst_b_i(rst_n),
    .select_load_n_i(select_load_n_i),
    .serial_in_i(serial_in_i),
    .serial_out_o(serial_out_o),
    .shift_o(link_word)
  );

  assign cs_rise = cs_sync && !q.cs_d;

  ////////////////////////////////////////////////////////////////////////////
  // word decode

  // only the last 24 bits count, so 24 and 32 bit frames look alike
  assign cmd = q.word[qdc_pkg::CMD_POS +: 4];
  assign addr = q.word[qdc_pkg::ADDR_POS +: 4];
  assign data = q.word[qdc_pkg::DATA_POS +: qdc_pkg::CODE_W];

  always_comb begin
    case (addr)
      qdc_pkg::ADDR_CHAN_A: sel = 4'h1;
      qdc_pkg::ADDR_CHAN_B: sel = 4'h2;
      qdc_pkg::ADDR_CHAN_C: sel = 4'h4;
      qdc_pkg::ADDR_CHAN_D: sel = 4'h8;
      qdc_pkg::ADDR_ALL: sel = 4'hf;
      // reserved addresses select no channel; write-and-update-all still updates every dac
      default: sel = 4'h0;
    endcase
  end

  // reserved commands fall through as no-ops
  assign is_write = (cmd == qdc_pkg::CMD_WRITE) ||
                    (cmd == qdc_pkg::CMD_WRITE_UPD_ALL) ||
                    (cmd == qdc_pkg::CMD_WRITE_UPD);
  assign is_pd = (cmd == qdc_pkg::CMD_POWER_DOWN);

  ////////////////////////////////////////////////////////////////////////////
  // per channel next values

  genvar i;
  generate
    for (i = 0; i < qdc_pkg::CHAN_N; i++) begin : g_chan
      assign up_en[i] = (((cmd == qdc_pkg::CMD_UPDATE) ||
                          (cmd == qdc_pkg::CMD_WRITE_UPD)) && sel[i]) ||
                        (cmd == qdc_pkg::CMD_WRITE_UPD_ALL);
      assign in_nx[i] = (is_write && sel[i]) ? data : q.in_reg[i];
      assign dac_nx[i] = up_en[i] ? in_nx[i] : q.dac_reg[i];
      // data field plays no part in power-down
      assign pd_nx[i] = up_en[i] ? 1'b0 :
                        ((is_pd && sel[i]) ? 1'b1 : q.pd[i]);
    end
  endgenerate

  // all four down means the shared bias restarts too
  assign wake = up_en & q.pd;
  always_comb begin
    if (&q.pd) begin
      settle_load = low_sync ? 13'(SETTLE_FULL_3V_CYC) :
                               13'(SETTLE_FULL_5V_CYC);
    end else begin
      settle_load = 13'(SETTLE_PART_CYC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    next_q = q;
    next_q.cs_d = cs_sync;
    if (q.settle != 13'h0000) begin
      next_q.settle = q.settle - 13'h0001;
    end
    case (q.st)
      qdc_pkg::ST_IDLE: begin
        if (cs_rise) begin
          next_q.word = link_word;
          next_q.st = qdc_pkg::ST_EXEC;
        end
      end
      qdc_pkg::ST_EXEC: begin
        next_q.in_reg = in_nx;
        next_q.dac_reg = dac_nx;
        next_q.pd = pd_nx;
        if (wake != 4'h0) begin
          next_q.settle = settle_load;
        end
        next_q.st = qdc_pkg::ST_IDLE;
      end
      default: begin
        next_q.st = qdc_pkg::ST_IDLE;
      end
    endcase
    // clear is a level: it holds the channel registers, power-down bits and settle count at zero while low
    if (!clr_sync) begin
      next_q.in_reg = '0;
      next_q.dac_reg = '0;
      next_q.pd = 4'h0;
      next_q.settle = 13'h0000;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      q.st <= qdc_pkg::ST_IDLE;
      q.cs_d <= 1'b1;
      q.word <= qdc_pkg::WORD_RST;
      q.in_reg <= {qdc_pkg::CHAN_N{qdc_pkg::CODE_RST}};
      q.dac_reg <= {qdc_pkg::CHAN_N{qdc_pkg::CODE_RST}};
      q.pd <= 4'h0;
      q.settle <= 13'h0000;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign input_code_o = q.in_reg;
  assign dac_code_o = q.dac_reg;
  assign power_down_o = q.pd;
  assign settling_o = (q.settle != 13'h0000);
  assign exec_o = (q.st == qdc_pkg::ST_EXEC);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic exec_ok;
  assign exec_ok = exec_o && clr_sync;

  sequence s_select_rise;
    cs_sync && !q.cs_d && (q.st == qdc_pkg::ST_IDLE);
  endsequence

  sequence s_exec_next;
    ##1 exec_o ##1 !exec_o;
  endsequence

  chk_rise_exec: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    s_select_rise |-> s_exec_next)
    else $error("select rise did not execute once");

  chk_word_taken: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    s_select_rise |=> q.word == $past(link_word))
    else $error("captured word differs from shifter");

  chk_write_input: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    exec_ok && is_write && sel[0] |=> q.in_reg[0] == $past(data))
    else $error("write did not reach input register");

  chk_write_keeps_dac: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    exec_ok && (cmd == qdc_pkg::CMD_WRITE) |=> $stable(q.dac_reg))
    else $error("plain write changed a dac register");

  chk_update_copy: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    exec_ok && (cmd == qdc_pkg::CMD_UPDATE) && sel[3]
    |=> q.dac_reg[3] == $past(q.in_reg[3]))
    else $error("update did not copy input register");

  chk_update_wakes: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    exec_ok && (up_en != 4'h0) |=> (q.pd & $past(up_en)) == 4'h0)
    else $error("updated channel still powered down");

  chk_pd_keeps_regs: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    exec_ok && is_pd
    |=> $stable(q.in_reg) && $stable(q.dac_reg) &&
        ((q.pd & $past(sel)) == $past(sel)))
    else $error("power-down disturbed registers or missed a channel");

  chk_nop_idle: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    exec_ok && (cmd == qdc_pkg::CMD_NOP)
    |=> $stable(q.in_reg) && $stable(q.dac_reg) && $stable(q.pd))
    else $error("no-op changed channel state");

  chk_clear_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    !clr_sync |=> (q.in_reg == '0) && (q.dac_reg == '0) && (q.pd == 4'h0))
    else $error("clear left a register set");

  chk_settle_part: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    exec_ok && (wake != 4'h0) && !(&q.pd)
    |=> (q.settle == 13'(SETTLE_PART_CYC)) ##1 settling_o [*8])
    else $error("partial wake settle time wrong");

  chk_settle_full: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    exec_ok && (wake != 4'h0) && (&q.pd)
    |=> q.settle == ($past(low_sync) ? 13'(SETTLE_FULL_3V_CYC) :
                                13'(SETTLE_FULL_5V_CYC)))
    else $error("full wake settle time wrong");

endmodule : qdc_serial_ctrl

// ===== tb/qdc_host_model.sv
// host side serial link model for the quad dac control block
module qdc_host_model (
  // serial pins towards the device
  output logic sck_o,
  output logic select_load_n_o,
  output logic serial_in_o,
  // daisy-chain return
  input wire logic serial_out_i
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [31:0] echo;

  initial begin
    sck_o = 1'b0;
    select_load_n_o = 1'b1;
    serial_in_o = 1'b0;
    echo = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one frame, msb first; the gap up front keeps sck clear of the last load
  task automatic send(input logic [31:0] w, input int n);
    #27.3;
    select_load_n_o = 1'b0;
    #8;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_o = w[i];
      #6 sck_o = 1'b1;
      #6 sck_o = 1'b0;
      #1 echo = {echo[30:0], serial_out_i};
    end
    #7;
    select_load_n_o = 1'b1;
    serial_in_o = ~serial_in_o;
  endtask : send

  // clocks with select high; data wiggles so a stray shift shows up
  task automatic idle_clocks(input int n);
    #27.3;
    for (int i = 0; i < n; i++) begin
      serial_in_o = ~serial_in_o;
      #6 sck_o = 1'b1;
      #6 sck_o = 1'b0;
    end
  endtask : idle_clocks
endmodule : qdc_host_model

// ===== tb/test_quad_dac_serial_control.sv
// self-checking bench for the quad dac serial control block
module test_quad_dac_serial_control;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int PART = 20;
  localparam int FULL5 = 40;
  localparam int FULL3 = 60;

  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic async_clear_n_i = 1'b1;
  logic low_supply_i = 1'b0;
  logic sck, sel_n, serial_in, serial_out;
  logic [3:0][15:0] in_code, dac_code, e_in, e_dac;
  logic [3:0] pd, e_pd;
  logic settling, exec;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  qdc_serial_ctrl #(.SETTLE_PART_CYC(PART), .SETTLE_FULL_5V_CYC(FULL5),
    .SETTLE_FULL_3V_CYC(FULL3)) dut (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .sck_i(sck), .select_load_n_i(sel_n),
    .serial_in_i(serial_in), .serial_out_o(serial_out),
    .async_clear_n_i(async_clear_n_i), .low_supply_i(low_supply_i),
    .input_code_o(in_code), .dac_code_o(dac_code), .power_down_o(pd),
    .settling_o(settling), .exec_o(exec));

  qdc_host_model host (.sck_o(sck), .select_load_n_o(sel_n),
    .serial_in_o(serial_in), .serial_out_i(serial_out));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] exp,
      input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic state(input string test);
    check("input codes", e_in, in_code);
    check("dac codes", e_dac, dac_code);
    check("power down", {60'h0, e_pd}, {60'h0, pd});
    $display("test %s done", test);
  endtask : state

  // exec pulse lasts one cycle, so poll every cycle under a bound
  task automatic frame(input logic [3:0] c, input logic [3:0] a,
      input logic [15:0] d, input int n);
    int k;
    k = 0;
    host.send({8'ha5, c, a, d}, n);
    while (exec !== 1'b1 && k < 40) begin
      @(negedge clk_sys_i);
      k++;
    end
    check("exec pulse", 64'h1, {63'h0, exec});
    @(negedge clk_sys_i);
  endtask : frame

  task automatic settle(input int exp);
    int k;
    k = 0;
    while (settling === 1'b1 && k < 200) begin
      @(negedge clk_sys_i);
      k++;
    end
    check("settle cycles", 64'(exp), 64'(k));
    check("settling low", 64'h0, {63'h0, settling});
  endtask : settle

  task automatic print_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_write_update();
    frame(4'h0, 4'h1, 16'h1234, 24);
    e_in[1] = 16'h1234;
    state("write");
    frame(4'h1, 4'h1, 16'hbeef, 24);
    e_dac[1] = 16'h1234;
    settle(0);
    state("update");
  endtask : t_write_update

  task automatic t_power_down();
    frame(4'h4, 4'hf, 16'hffff, 24);
    e_pd = 4'hf;
    state("power down all");
    frame(4'h3, 4'h2, 16'habcd, 32);
    e_in[2] = 16'habcd;
    e_dac[2] = 16'habcd;
    e_pd = 4'hb;
    settle(FULL5);
    state("wake from all down");
    frame(4'h2, 4'h0, 16'h0111, 24);
    e_in[0] = 16'h0111;
    e_dac = e_in;
    e_pd = 4'h0;
    settle(PART);
    state("write one update all");
  endtask : t_power_down

  task automatic t_low_supply();
    frame(4'h4, 4'hf, 16'h0000, 24);
    low_supply_i = 1'b1;
    frame(4'h1, 4'hf, 16'h5555, 24);
    settle(FULL3);
    low_supply_i = 1'b0;
    state("wake at low supply");
  endtask : t_low_supply

  task automatic t_chain_nop();
    frame(4'hf, 4'hf, 16'h9999, 32);
    frame(4'h0, 4'h5, 16'h7777, 24);
    state("no-op and reserved address");
    host.idle_clocks(5);
    frame(4'hf, 4'h0, 16'h0000, 32);
    // shifter held 0x99 then 0x057777; echo lags 31 rises
    check("daisy echo", {32'h0, 32'h320a_eeef},
      {32'h0, host.echo});
    state("daisy chain");
  endtask : t_chain_nop

  task automatic t_clear();
    async_clear_n_i = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    e_in = '0;
    e_dac = '0;
    e_pd = 4'h0;
    state("clear");
    async_clear_n_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
  endtask : t_clear

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    e_in = '0;
    e_dac = '0;
    e_pd = 4'h0;
    repeat (4) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    check("settling", 64'h0, {63'h0, settling});
    state("reset");
    t_write_update();
    t_power_down();
    t_low_supply();
    t_chain_nop();
    t_clear();
    print_verdict();
  end
endmodule : test_quad_dac_serial_control
